// ===== design/cpu_ctl_pkg.sv
// Purpose: shared constants and types of the processor control core
// Assumes: 8-bit data, 16-bit addresses, one clock
// Notes: state codes step in Gray order along the fetch path
package cpu_ctl_pkg;
	localparam logic [15:0] RESET_VEC = 16'hFFFE;
	localparam logic [15:0] TRAP_VEC = 16'hFFFC;
	localparam logic [15:0] MON_TRAP_VEC = 16'hFEFC;
	localparam logic [15:0] IRQ_VEC_TOP = 16'hFFFA;
	localparam logic [15:0] STK_RESET = 16'h00FF;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] OSC_STAB_CYCLES = 16'h1000;
	localparam logic [2:0] PUSH_LAST = 3'h4;
	localparam logic [7:0] STOP_WAKE_MASK = 8'h01;
	localparam logic [7:0] OP_ASLA = 8'h48;
	localparam logic [7:0] OP_ASLX = 8'h58;
	localparam logic [7:0] OP_PREFIX = 8'h9E;
	localparam logic [7:0] OP_SHL_STK = 8'h68;
	localparam logic [7:0] OP_STK_ADJ = 8'hA7;
	localparam logic [7:0] OP_IDX_ADJ = 8'hAF;
	localparam logic [7:0] OP_BR_NC = 8'h24;
	localparam logic [7:0] OP_ADD = 8'hAB;
	localparam logic [7:0] OP_ADC = 8'hA9;
	localparam logic [7:0] OP_UNMASK = 8'h9A;
	localparam logic [7:0] OP_TRAP = 8'h83;
	localparam logic [7:0] OP_RET = 8'h80;
	localparam logic [7:0] OP_WAIT = 8'h8F;
	localparam logic [7:0] OP_STOP = 8'h8E;
	localparam logic [7:0] OP_PUSH_HI = 8'h8B;
	localparam logic [7:0] OP_POP_HI = 8'h8A;
	localparam logic [7:0] REG_IP = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0C;
	localparam int CTRL_BRK_EN = 0;
	localparam int CTRL_MON = 1;
	localparam logic [7:0] FLAGS_RESET = 8'h68;
	typedef struct packed {
		logic v;
		logic one_a;
		logic one_b;
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} flags_t;
	typedef enum logic [1:0] {ALU_ADD, ALU_ADC, ALU_ASL} alu_op_t;
	typedef struct packed {
		logic [7:0] res;
		logic v;
		logic h;
		logic n;
		logic z;
		logic c;
	} alu_out_t;
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic [7:0] wdata;
	} mem_req_t;
	typedef enum logic [3:0] {
		S_RST_HI = 4'h0, S_RST_LO = 4'h1, S_FETCH = 4'h3, S_OPER = 4'h2,
		S_BRANCH = 4'h6, S_PREFIX = 4'h7, S_SH_OFF = 4'h5, S_SH_RD = 4'h4,
		S_STORE = 4'hC, S_PUSH = 4'hD, S_VEC_HI = 4'hF, S_VEC_LO = 4'hE,
		S_PULL = 4'hA, S_PULLH = 4'hB, S_LOWPWR = 4'h9
	} state_t;
endpackage

// ===== design/flag_alu.sv
// Purpose: result and flag generation for sums and left shifts
// Assumes: purely combinational, operands from the sequencer
// Notes: half-carry is only meaningful for the two sum forms
module flag_alu (
	// operation
	input wire cpu_ctl_pkg::alu_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	// result
	output cpu_ctl_pkg::alu_out_t out
);
	logic [8:0] sum;
	logic [7:0] r;
	logic cy;

	always_comb begin
		sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == cpu_ctl_pkg::ALU_ADC) & cin};
		if (op == cpu_ctl_pkg::ALU_ASL) begin
			r = {a[6:0], 1'b0};
			cy = a[7];
		end else begin
			r = sum[7:0];
			cy = sum[8];
		end
		out.res = r;
		out.c = cy;
		out.n = r[7];
		out.z = (r == 8'h00);
		out.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
		if (op == cpu_ctl_pkg::ALU_ASL) begin
			// shift overflow is sign change, i.e. new sign differs from carry
			out.v = r[7] ^ cy;
		end else begin
			out.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
		end
	end
endmodule // flag_alu

// ===== design/cpu_flags_pc_control.sv
// Purpose: instruction pointer, flags and trap sequencing of an 8-bit core
// Assumes: memory answers mem_rdata in the cycle its address is presented
// Notes: registers reached over AHB-Lite, zero wait states
// Behaviour
// - pointer steps once per fetched byte
// - jumps, branches, traps load a target
// - reset fetches start address from top vector
// - flags eight bits, bits six, five one
// - overflow flag tracks signed overflow
// - half-carry from bit three on sums
// - mask set blocks maskable requests
// - push state, then mask, then vector
// - upper index byte never pushed on entry
// - highest priority request served first
// - return pulls state, restores stacked mask
// - reset masks; unmask, wait and stop ops clear
// - negative flag copies result bit seven
// - zero flag set for zero result
// - carry from bit seven or borrow
// - wait unmasks, stops clock, interrupt wakes
// - stop unmasks, wakes, waits oscillator delay
// - break forces trap, vector by mode
// - stack offset op adds signed byte
// - index offset op adds signed byte
// - branch on no carry, three cycles
// - left shift forms, flags, cycle counts
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module cpu_flags_pc_control (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// memory bus
	input wire logic [7:0] mem_rdata,
	output cpu_ctl_pkg::mem_req_t mem_q,
	// interrupt, break and clock logic
	input wire logic [7:0] irq_req,
	input wire logic break_req,
	output logic cpu_clk_en_q
);
	cpu_ctl_pkg::state_t state_q, state_d;
	cpu_ctl_pkg::flags_t fl_q, fl_d, fl_bus;
	cpu_ctl_pkg::mem_req_t mq_d;
	cpu_ctl_pkg::alu_op_t alu_op;
	cpu_ctl_pkg::alu_out_t alu;
	logic [15:0] ip_q, ip_d, sp_q, sp_d, vec_q, vec_d, trap_vec, ret_ip;
	logic [15:0] osc_q, osc_d;
	logic [7:0] a_q, a_d, x_q, x_d, h_q, h_d, op_q, op_d, tmp_q, tmp_d;
	logic [7:0] alu_a, dp_addr_q;
	logic [2:0] cnt_q, cnt_d;
	logic [1:0] ctrl_q;
	logic [31:0] rd_word;
	logic stop_q, stop_d, clk_en_d, dp_wr_q, fl_wr;
	logic brk_go, irq_go, trap_op, trap_go, wake;

	function automatic logic [15:0] sext16(input logic [7:0] b);
		sext16 = {{8{b[7]}}, b};
	endfunction

	// lowest index is the most urgent request
	function automatic logic [2:0] prio_idx(input logic [7:0] r);
		prio_idx = 3'h0;
		for (int k = 7; k >= 0; k--) begin
			if (r[k]) begin
				prio_idx = 3'(k);
			end
		end
	endfunction

	// v, n, z, c always; h only for the sum forms
	function automatic cpu_ctl_pkg::flags_t put_alu(
		input cpu_ctl_pkg::flags_t f, input cpu_ctl_pkg::alu_out_t r,
		input logic with_h);
		put_alu = f;
		put_alu.v = r.v;
		put_alu.n = r.n;
		put_alu.z = r.z;
		put_alu.c = r.c;
		if (with_h) begin
			put_alu.h = r.h;
		end
	endfunction

	flag_alu u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(mem_rdata),
		.cin(fl_q.c),
		.out(alu)
	);

	always_comb begin
		alu_op = cpu_ctl_pkg::ALU_ASL;
		alu_a = a_q;
		case (state_q)
			cpu_ctl_pkg::S_FETCH: begin
				alu_a = (mem_rdata == cpu_ctl_pkg::OP_ASLX) ? x_q : a_q;
			end
			cpu_ctl_pkg::S_OPER: begin
				alu_op = (op_q == cpu_ctl_pkg::OP_ADC) ?
					cpu_ctl_pkg::ALU_ADC : cpu_ctl_pkg::ALU_ADD;
			end
			cpu_ctl_pkg::S_SH_RD: begin
				alu_a = mem_rdata;
			end
			default: begin
			end
		endcase
	end

	// taken only at an instruction boundary, so the current one completes
	assign brk_go = ctrl_q[cpu_ctl_pkg::CTRL_BRK_EN] & break_req;
	assign irq_go = (|irq_req) & ~fl_q.i;
	assign trap_op = (mem_rdata == cpu_ctl_pkg::OP_TRAP);
	assign trap_go = brk_go | irq_go | trap_op;
	assign ret_ip = (trap_op & ~brk_go & ~irq_go) ?
		ip_q + cpu_ctl_pkg::ONE16 : ip_q;
	assign fl_wr = dp_wr_q && (dp_addr_q == cpu_ctl_pkg::REG_FLAGS);
	assign fl_bus = fl_wr ? cpu_ctl_pkg::flags_t'(hwdata[7:0]) : fl_q;
	assign wake = stop_q ? |(irq_req & cpu_ctl_pkg::STOP_WAKE_MASK) :
		((|irq_req) | brk_go);

	always_comb begin
		if (brk_go || (trap_op && !irq_go)) begin
			trap_vec = ctrl_q[cpu_ctl_pkg::CTRL_MON] ?
				cpu_ctl_pkg::MON_TRAP_VEC : cpu_ctl_pkg::TRAP_VEC;
		end else begin
			trap_vec = cpu_ctl_pkg::IRQ_VEC_TOP -
				{12'h000, prio_idx(irq_req), 1'b0};
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		ip_d = ip_q;
		sp_d = sp_q;
		a_d = a_q;
		x_d = x_q;
		h_d = h_q;
		op_d = op_q;
		tmp_d = tmp_q;
		vec_d = vec_q;
		stop_d = stop_q;
		osc_d = osc_q;
		clk_en_d = cpu_clk_en_q;
		fl_d = fl_bus;
		mq_d = '{addr: mem_q.addr, wr: 1'b0, wdata: mem_q.wdata};
		case (state_q)
			cpu_ctl_pkg::S_RST_HI: begin
				tmp_d = mem_rdata;
				mq_d.addr = cpu_ctl_pkg::RESET_VEC + cpu_ctl_pkg::ONE16;
				state_d = cpu_ctl_pkg::S_RST_LO;
			end
			cpu_ctl_pkg::S_RST_LO: begin
				ip_d = {tmp_q, mem_rdata};
				mq_d.addr = ip_d;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_FETCH: begin
				op_d = mem_rdata;
				ip_d = ip_q + cpu_ctl_pkg::ONE16;
				mq_d.addr = ip_d;
				if (trap_go) begin
					// for break and interrupts the pending opcode is refetched after the service returns; a trap op is skipped
					ip_d = ret_ip;
					vec_d = trap_vec;
					cnt_d = 3'h0;
					mq_d = '{addr: sp_q, wr: 1'b1, wdata: ret_ip[7:0]};
					sp_d = sp_q - cpu_ctl_pkg::ONE16;
					state_d = cpu_ctl_pkg::S_PUSH;
				end else begin
					case (mem_rdata)
						cpu_ctl_pkg::OP_ASLA: begin
							a_d = alu.res;
							fl_d = put_alu(fl_d, alu, 1'b0);
						end
						cpu_ctl_pkg::OP_ASLX: begin
							x_d = alu.res;
							fl_d = put_alu(fl_d, alu, 1'b0);
						end
						cpu_ctl_pkg::OP_STK_ADJ, cpu_ctl_pkg::OP_IDX_ADJ,
						cpu_ctl_pkg::OP_BR_NC,
						cpu_ctl_pkg::OP_ADD, cpu_ctl_pkg::OP_ADC: begin
							state_d = cpu_ctl_pkg::S_OPER;
						end
						cpu_ctl_pkg::OP_PREFIX: begin
							state_d = cpu_ctl_pkg::S_PREFIX;
						end
						cpu_ctl_pkg::OP_UNMASK: begin
							fl_d.i = 1'b0;
						end
						cpu_ctl_pkg::OP_WAIT, cpu_ctl_pkg::OP_STOP: begin
							fl_d.i = 1'b0;
							clk_en_d = 1'b0;
							stop_d = (mem_rdata == cpu_ctl_pkg::OP_STOP);
							state_d = cpu_ctl_pkg::S_LOWPWR;
						end
						cpu_ctl_pkg::OP_RET: begin
							sp_d = sp_q + cpu_ctl_pkg::ONE16;
							mq_d.addr = sp_d;
							cnt_d = 3'h0;
							state_d = cpu_ctl_pkg::S_PULL;
						end
						cpu_ctl_pkg::OP_PUSH_HI: begin
							mq_d = '{addr: sp_q, wr: 1'b1, wdata: h_q};
							sp_d = sp_q - cpu_ctl_pkg::ONE16;
							state_d = cpu_ctl_pkg::S_STORE;
						end
						cpu_ctl_pkg::OP_POP_HI: begin
							sp_d = sp_q + cpu_ctl_pkg::ONE16;
							mq_d.addr = sp_d;
							state_d = cpu_ctl_pkg::S_PULLH;
						end
						default: begin
						end
					endcase
				end
			end
			cpu_ctl_pkg::S_OPER: begin
				ip_d = ip_q + cpu_ctl_pkg::ONE16;
				mq_d.addr = ip_d;
				tmp_d = mem_rdata;
				state_d = cpu_ctl_pkg::S_FETCH;
				case (op_q)
					cpu_ctl_pkg::OP_STK_ADJ: begin
						sp_d = sp_q + sext16(mem_rdata);
					end
					cpu_ctl_pkg::OP_IDX_ADJ: begin
						{h_d, x_d} = {h_q, x_q} + sext16(mem_rdata);
					end
					cpu_ctl_pkg::OP_BR_NC: begin
						state_d = cpu_ctl_pkg::S_BRANCH;
					end
					default: begin
						a_d = alu.res;
						fl_d = put_alu(fl_d, alu, 1'b1);
					end
				endcase
			end
			cpu_ctl_pkg::S_BRANCH: begin
				if (!fl_q.c) begin
					ip_d = ip_q + sext16(tmp_q);
				end
				mq_d.addr = ip_d;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_PREFIX: begin
				ip_d = ip_q + cpu_ctl_pkg::ONE16;
				mq_d.addr = ip_d;
				state_d = (mem_rdata == cpu_ctl_pkg::OP_SHL_STK) ?
					cpu_ctl_pkg::S_SH_OFF : cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_SH_OFF: begin
				ip_d = ip_q + cpu_ctl_pkg::ONE16;
				mq_d.addr = sp_q + {8'h00, mem_rdata};
				state_d = cpu_ctl_pkg::S_SH_RD;
			end
			cpu_ctl_pkg::S_SH_RD: begin
				fl_d = put_alu(fl_d, alu, 1'b0);
				mq_d.wr = 1'b1;
				mq_d.wdata = alu.res;
				state_d = cpu_ctl_pkg::S_STORE;
			end
			cpu_ctl_pkg::S_STORE: begin
				mq_d.addr = ip_q;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_PUSH: begin
				if (cnt_q == cpu_ctl_pkg::PUSH_LAST) begin
					fl_d.i = 1'b1;
					mq_d.addr = vec_q;
					state_d = cpu_ctl_pkg::S_VEC_HI;
				end else begin
					cnt_d = cnt_q + 3'h1;
					mq_d.addr = sp_q;
					mq_d.wr = 1'b1;
					// order: pointer low, pointer high, X, A, flags
					case (cnt_q)
						3'h0: mq_d.wdata = ip_q[15:8];
						3'h1: mq_d.wdata = x_q;
						3'h2: mq_d.wdata = a_q;
						default: mq_d.wdata = fl_q;
					endcase
					sp_d = sp_q - cpu_ctl_pkg::ONE16;
				end
			end
			cpu_ctl_pkg::S_VEC_HI: begin
				tmp_d = mem_rdata;
				mq_d.addr = vec_q + cpu_ctl_pkg::ONE16;
				state_d = cpu_ctl_pkg::S_VEC_LO;
			end
			cpu_ctl_pkg::S_VEC_LO: begin
				ip_d = {tmp_q, mem_rdata};
				mq_d.addr = ip_d;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_PULL: begin
				case (cnt_q)
					3'h0: fl_d = cpu_ctl_pkg::flags_t'(mem_rdata);
					3'h1: a_d = mem_rdata;
					3'h2: x_d = mem_rdata;
					3'h3: tmp_d = mem_rdata;
					default: ip_d = {tmp_q, mem_rdata};
				endcase
				if (cnt_q == cpu_ctl_pkg::PUSH_LAST) begin
					mq_d.addr = ip_d;
					state_d = cpu_ctl_pkg::S_FETCH;
				end else begin
					cnt_d = cnt_q + 3'h1;
					sp_d = sp_q + cpu_ctl_pkg::ONE16;
					mq_d.addr = sp_d;
				end
			end
			cpu_ctl_pkg::S_PULLH: begin
				h_d = mem_rdata;
				mq_d.addr = ip_q;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
			cpu_ctl_pkg::S_LOWPWR: begin
				if (osc_q != 16'h0000) begin
					osc_d = osc_q - cpu_ctl_pkg::ONE16;
				end else if (wake && stop_q) begin
					osc_d = cpu_ctl_pkg::OSC_STAB_CYCLES;
				end
				if ((osc_q == cpu_ctl_pkg::ONE16) || (wake && !stop_q)) begin
					// mask untouched, so the waking request is taken next
					clk_en_d = 1'b1;
					stop_d = 1'b0;
					mq_d.addr = ip_q;
					state_d = cpu_ctl_pkg::S_FETCH;
				end
			end
			default: begin
				mq_d.addr = ip_q;
				state_d = cpu_ctl_pkg::S_FETCH;
			end
		endcase
		fl_d.one_a = 1'b1;
		fl_d.one_b = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= cpu_ctl_pkg::S_RST_HI;
			cnt_q <= 3'h0;
			stop_q <= 1'b0;
			osc_q <= 16'h0000;
			cpu_clk_en_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			stop_q <= stop_d;
			osc_q <= osc_d;
			cpu_clk_en_q <= clk_en_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ip_q <= 16'h0000;
			sp_q <= cpu_ctl_pkg::STK_RESET;
			a_q <= 8'h00;
			x_q <= 8'h00;
			h_q <= 8'h00;
			op_q <= 8'h00;
			tmp_q <= 8'h00;
			vec_q <= 16'h0000;
		end else begin
			ip_q <= ip_d;
			sp_q <= sp_d;
			a_q <= a_d;
			x_q <= x_d;
			h_q <= h_d;
			op_q <= op_d;
			tmp_q <= tmp_d;
			vec_q <= vec_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fl_q <= cpu_ctl_pkg::flags_t'(cpu_ctl_pkg::FLAGS_RESET);
		end else begin
			fl_q <= fl_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_q <= '{addr: cpu_ctl_pkg::RESET_VEC, wr: 1'b0, wdata: 8'h00};
		end else begin
			mem_q <= mq_d;
		end
	end

	always_comb begin
		case (haddr[7:0])
			cpu_ctl_pkg::REG_IP: rd_word = {16'h0000, ip_q};
			cpu_ctl_pkg::REG_FLAGS: rd_word = {24'h000000, fl_q};
			cpu_ctl_pkg::REG_STATUS: rd_word = {26'h0, cpu_clk_en_q, stop_q, state_q};
			cpu_ctl_pkg::REG_CTRL: rd_word = {30'h0, ctrl_q};
			default: rd_word = 32'h00000000;
		endcase
	end

	// zero wait states; the read word is latched in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			dp_wr_q <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1]) begin
				dp_addr_q <= haddr[7:0];
				if (!hwrite) begin
					hrdata <= rd_word;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= 2'h0;
		end else if (dp_wr_q && (dp_addr_q == cpu_ctl_pkg::REG_CTRL)) begin
			ctrl_q <= hwdata[1:0];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_push5;
		(state_q == cpu_ctl_pkg::S_PUSH && mem_q.wr)[*5];
	endsequence
	sequence s_vec_fetch;
		state_q == cpu_ctl_pkg::S_VEC_HI && fl_q.i && !mem_q.wr &&
			mem_q.addr == vec_q;
	endsequence
	sequence s_brnc_go;
		state_q == cpu_ctl_pkg::S_FETCH && !trap_go &&
			mem_rdata == cpu_ctl_pkg::OP_BR_NC;
	endsequence

	a_fetch_addr: assert property (state_q == cpu_ctl_pkg::S_FETCH |->
		mem_q.addr == ip_q && !mem_q.wr)
		else $error("fetch address differs from pointer");
	a_fixed_ones: assert property (fl_q.one_a && fl_q.one_b)
		else $error("fixed flag bits not one");
	a_reset_vec: assert property (state_q == cpu_ctl_pkg::S_RST_LO |=>
		state_q == cpu_ctl_pkg::S_FETCH &&
		ip_q == {$past(tmp_q), $past(mem_rdata)})
		else $error("reset vector not loaded");
	a_mask_blocks: assert property (state_q == cpu_ctl_pkg::S_FETCH &&
		fl_q.i && !brk_go && !trap_op |-> !trap_go)
		else $error("masked request accepted");
	a_trap_order: assert property (state_q == cpu_ctl_pkg::S_FETCH &&
		trap_go |=> s_push5 ##1 s_vec_fetch)
		else $error("trap entry order wrong");
	a_push_count: assert property (state_q == cpu_ctl_pkg::S_PUSH &&
		cnt_q == cpu_ctl_pkg::PUSH_LAST |=> state_q == cpu_ctl_pkg::S_VEC_HI)
		else $error("trap pushed more than five bytes");
	a_ret_mask: assert property (state_q == cpu_ctl_pkg::S_PULL &&
		cnt_q == 3'h0 |=> fl_q.i == $past(mem_rdata[3]))
		else $error("mask not restored from stack");
	a_brnc_three: assert property (s_brnc_go |=>
		state_q == cpu_ctl_pkg::S_OPER ##1 state_q == cpu_ctl_pkg::S_BRANCH
		##1 state_q == cpu_ctl_pkg::S_FETCH && fl_q == $past(fl_q, 3))
		else $error("branch timing or flags wrong");
	a_asla_one: assert property (state_q == cpu_ctl_pkg::S_FETCH &&
		!trap_go && mem_rdata == cpu_ctl_pkg::OP_ASLA |=>
		state_q == cpu_ctl_pkg::S_FETCH && fl_q.c == $past(a_q[7]) &&
		a_q == {$past(a_q[6:0]), 1'b0})
		else $error("accumulator shift wrong");
	a_half_carry: assert property (state_q == cpu_ctl_pkg::S_OPER &&
		op_q == cpu_ctl_pkg::OP_ADD |=> fl_q.h ==
		(({1'b0, $past(a_q[3:0])} + {1'b0, $past(mem_rdata[3:0])}) >= 5'h10))
		else $error("half carry wrong");
	a_lowpwr_clk: assert property (state_q == cpu_ctl_pkg::S_LOWPWR |->
		!cpu_clk_en_q && !fl_q.i)
		else $error("clock or mask wrong in low power");
endmodule // cpu_flags_pc_control

// ===== testbench/mem_model.sv
// Purpose: byte memory on the far side of the core's memory bus
// Assumes: read answers in the cycle its address is shown
// Notes: filler byte is a one-cycle no-op, so stray fetches stay harmless
module mem_model (
	// clock
	input wire logic hclk,
	// memory bus
	input wire cpu_ctl_pkg::mem_req_t mem_q,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ram [0:65535];
	assign mem_rdata = ram[mem_q.addr];
	// write lands at the edge that ends the strobe cycle
	always @(posedge hclk) begin
		if (mem_q.wr === 1'b1) begin
			ram[mem_q.addr] <= mem_q.wdata;
		end
	end
	task automatic clear();
		for (int k = 0; k < 65536; k++) begin
			ram[k] = 8'hA5;
		end
	endtask
endmodule // mem_model

// ===== testbench/test_cpu_flags_pc_control.sv
// Purpose: self-checking bench for the processor control core
// Assumes: zero-wait register bus, memory model answers same cycle
// Notes: each row reloads memory and resets, so rows stay independent
module test_cpu_flags_pc_control;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] fin;
		logic [7:0] fexp;
		logic [31:0] prog;
	} row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [7:0] mem_rdata;
	cpu_ctl_pkg::mem_req_t mem_q;
	logic [7:0] irq_req = 8'h00;
	logic break_req = 1'b0;
	logic cpu_clk_en_q;
	logic [31:0] rd;
	int miscompares = 0;
	int n_compared = 0;
	int cnt;
	// state comes in by a return pull, the op runs, then a halt op stops it
	row_t rows [9] = '{
		'{8'h08, 8'h00, 8'h60, 8'h70, 32'hAB088F8F},
		'{8'h80, 8'h00, 8'h60, 8'hE3, 32'hAB808F8F},
		'{8'h7F, 8'h00, 8'h61, 8'hF4, 32'hA9008F8F},
		'{8'hC0, 8'h00, 8'h70, 8'h75, 32'h488F8F8F},
		'{8'h80, 8'h00, 8'h60, 8'hE3, 32'h488F8F8F},
		'{8'h00, 8'h40, 8'h63, 8'hE4, 32'h588F8F8F},
		'{8'h00, 8'h00, 8'hF3, 8'hF3, 32'hA7058F8F},
		'{8'h00, 8'h00, 8'hE5, 8'hE5, 32'hAFFB8F8F},
		'{8'h00, 8'h00, 8'h60, 8'hE4, 32'h9E68028F}
	};
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	cpu_flags_pc_control i_cpu_flags_pc_control (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .mem_rdata, .mem_q,
		.irq_req, .break_req, .cpu_clk_en_q
	);
	mem_model mem (.hclk, .mem_q, .mem_rdata);
	task automatic close_out();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		miscompares++;
		$display("[ERR] %0t wait ran out", $time);
		close_out();
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 50) tmo();
		end while (hreadyout !== 1'b1);
	endtask
	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	function automatic logic cond(input int k, input logic [15:0] a);
		case (k)
			0: return cpu_clk_en_q === 1'b0;
			1: return cpu_clk_en_q === 1'b1;
			2: return mem_q.addr === a;
			default: return mem_q.wr === 1'b1 && mem_q.addr === a;
		endcase
	endfunction
	// kinds: 0 halted, 1 running, 2 address shown, 3 write to address
	task automatic wait_on(input int k, input logic [15:0] a);
		cnt = 0;
		do begin
			@(posedge hclk);
			#1;
			cnt++;
			if (cnt > 6000) tmo();
		end while (!cond(k, a));
	endtask
	task automatic put(input logic [15:0] a, input logic [7:0] d);
		mem.ram[a] = d;
	endtask
	task automatic vec(input logic [15:0] a, input logic [15:0] d);
		put(a, d[15:8]);
		put(a + 16'h1, d[7:0]);
	endtask
	task automatic reset_run();
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		chk(mem_q.addr, 16'hFFFE);
		hresetn <= 1'b1;
	endtask
	initial begin
		foreach (rows[r]) begin
			mem.clear();
			vec(16'hFFFE, 16'h1000);
			put(16'h1000, cpu_ctl_pkg::OP_RET);
			vec(16'h0100, {rows[r].fin, rows[r].a});
			vec(16'h0102, {rows[r].x, 8'h20});
			put(16'h0104, 8'h00);
			put(16'h0106, 8'h41);
			vec(16'h2000, rows[r].prog[31:16]);
			vec(16'h2002, rows[r].prog[15:0]);
			reset_run();
			wait_on(0, 16'h0);
			bus(1'b0, cpu_ctl_pkg::REG_FLAGS, 32'h0);
			chk(rd, {24'h0, rows[r].fexp});
		end
		// branch, trap, masked and prioritised interrupts, break
		mem.clear();
		vec(16'hFFFE, 16'h1000);
		vec(16'h1000, 16'h2410);
		put(16'h1012, cpu_ctl_pkg::OP_TRAP);
		vec(16'hFFFC, 16'h3000);
		put(16'h3000, cpu_ctl_pkg::OP_WAIT);
		vec(16'hFFF4, 16'h4000);
		put(16'h4000, cpu_ctl_pkg::OP_WAIT);
		vec(16'hFFF8, 16'h5000);
		vec(16'hFFF6, 16'h6000);
		put(16'h5000, cpu_ctl_pkg::OP_WAIT);
		put(16'h5001, cpu_ctl_pkg::OP_WAIT);
		vec(16'hFEFC, 16'h7000);
		put(16'h7000, cpu_ctl_pkg::OP_RET);
		irq_req <= 8'h08;
		reset_run();
		bus(1'b0, cpu_ctl_pkg::REG_FLAGS, 32'h0);
		chk(rd, 32'h68);
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wait_on(3, 16'h00F6);
		@(posedge hclk);
		irq_req <= 8'h00;
		wait_on(0, 16'h0);
		chk(mem.ram[16'h00FF], 8'h13);
		chk(mem.ram[16'h00FE], 8'h10);
		chk(mem.ram[16'h00FB], 8'h68);
		chk(mem.ram[16'h00F6], 8'h60);
		bus(1'b1, cpu_ctl_pkg::REG_FLAGS, 32'h0);
		bus(1'b0, cpu_ctl_pkg::REG_FLAGS, 32'h0);
		chk(rd, 32'h60);
		@(posedge hclk);
		irq_req <= 8'h06;
		wait_on(3, 16'h00F1);
		@(posedge hclk);
		irq_req <= 8'h00;
		wait_on(0, 16'h0);
		bus(1'b0, cpu_ctl_pkg::REG_IP, 32'h0);
		chk(rd[15:8], 8'h50);
		bus(1'b1, cpu_ctl_pkg::REG_CTRL, 32'h3);
		bus(1'b0, cpu_ctl_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h3);
		@(posedge hclk);
		break_req <= 1'b1;
		wait_on(2, 16'h7000);
		@(posedge hclk);
		break_req <= 1'b0;
		wait_on(0, 16'h0);
		bus(1'b0, cpu_ctl_pkg::REG_IP, 32'h0);
		chk(rd[15:8], 8'h50);
		// stop: wake by the top request only after the settle delay
		mem.clear();
		vec(16'hFFFE, 16'h1000);
		put(16'h1000, cpu_ctl_pkg::OP_STOP);
		vec(16'hFFFA, 16'h1000);
		reset_run();
		wait_on(0, 16'h0);
		@(posedge hclk);
		irq_req <= 8'h01;
		wait_on(1, 16'h0);
		chk(cnt >= 4096 && cnt <= 4104, 1'b1);
		wait_on(3, 16'h00FB);
		@(posedge hclk);
		irq_req <= 8'h00;
		wait_on(0, 16'h0);
		chk(mem.ram[16'h00FB], 8'h60);
		// stack and index offsets, then the upper index byte pushed at new top
		mem.clear();
		vec(16'hFFFE, 16'h1000);
		vec(16'h1000, 16'hA705);
		vec(16'h1002, 16'hAFFB);
		vec(16'h1004, 16'h8B8F);
		reset_run();
		wait_on(0, 16'h0);
		chk(mem.ram[16'h0104], 8'hFF);
		close_out();
	end
endmodule // test_cpu_flags_pc_control
